// >>> uhri_pkg.sv
// package: register map, field positions, reset values and types of the uart holding block
package uhri_pkg;
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_IER  = 3'h1;
  localparam logic [2:0] ADDR_FCR  = 3'h2;
  localparam logic [2:0] ADDR_LSR  = 3'h5;
  localparam logic [2:0] ADDR_MSR  = 3'h6;
  localparam logic [7:0] IER_RST   = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam int IER_CTS   = 7;
  localparam int IER_RTS   = 6;
  localparam int IER_XOFF  = 5;
  localparam int IER_SLEEP = 4;
  localparam int IER_MODEM = 3;
  localparam int IER_LINE  = 2;
  localparam int IER_TXE   = 1;
  localparam int IER_RXR   = 0;
  localparam int FCR_FIFO_EN = 0;
  localparam int FCR_RX_RST  = 1;
  localparam int FCR_TX_RST  = 2;
  localparam logic [3:0] START_MID_TICK = 4'h7;
  localparam logic [3:0] BIT_LAST_TICK  = 4'hf;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam int PIN_CTS = 0;
  localparam int PIN_DSR = 1;
  localparam int PIN_RI  = 2;
  localparam int PIN_CD  = 3;
  localparam int PIN_RTS = 4;
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uhri_req_t;
  typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} uhri_ser_t;
endpackage : uhri_pkg

// >>> uhri_chan.sv
// module: one uart channel holding paths, line/modem status and interrupt enable
`timescale 1ns/1ps
module uhri_chan
  import uhri_pkg::*;
#(
  parameter int DEPTH   = 16,
  parameter int RX_TRIG = 1
) (
  input  wire logic      clk_i,
  input  wire logic      rstn_i,
  input  wire uhri_req_t host_req_i,
  output logic [7:0]     rdata_o,
  input  wire logic      baud_tick_i,
  input  wire logic      rxd_i,
  output logic           txd_o,
  input  wire logic      cts_i,
  input  wire logic      dsr_i,
  input  wire logic      ri_i,
  input  wire logic      cd_i,
  input  wire logic      rts_i,
  input  wire logic      enh_feature_en_i,
  input  wire logic      xoff_rx_i,
  output logic           irq_o,
  output logic           sleep_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE  = (AW+1)'(1);
  localparam logic [AW:0] CNT_TRIG = (AW+1)'(RX_TRIG);

  function automatic logic acc(input uhri_req_t q, input logic [2:0] a, input logic rd);
    acc = q.cs && (rd ? q.rd : q.wr) && (q.addr == a);
  endfunction : acc

  logic hold_wr, hold_rd, ier_wr, fcr_wr, lsr_rd, msr_rd, rd_any;
  assign hold_wr = acc(host_req_i, ADDR_HOLD, 1'b0);
  assign hold_rd = acc(host_req_i, ADDR_HOLD, 1'b1);
  assign ier_wr  = acc(host_req_i, ADDR_IER, 1'b0);
  assign fcr_wr  = acc(host_req_i, ADDR_FCR, 1'b0);
  assign lsr_rd  = acc(host_req_i, ADDR_LSR, 1'b1);
  assign msr_rd  = acc(host_req_i, ADDR_MSR, 1'b1);
  assign rd_any  = host_req_i.cs && host_req_i.rd;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect
  logic [4:0] pin_s1_r, pin_s2_r, pin_prev_r, pin_raw;
  logic [4:0] pin_rise, pin_chg;
  assign pin_raw  = {rts_i, cd_i, ri_i, dsr_i, cts_i};
  assign pin_rise = pin_s2_r & ~pin_prev_r;
  assign pin_chg  = pin_s2_r ^ pin_prev_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_s1_r   <= 5'h00;
      pin_s2_r   <= 5'h00;
      pin_prev_r <= 5'h00;
    end else begin
      pin_s1_r   <= pin_raw;
      pin_s2_r   <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit fifo and shifter
  logic [7:0]  tx_mem [DEPTH];
  logic [AW-1:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
  logic [AW:0] tx_cnt_r, tx_cnt_nxt;
  uhri_ser_t   tx_st_r, tx_st_nxt;
  logic [3:0]  tx_tick_r, tx_tick_nxt;
  logic [2:0]  tx_bit_r, tx_bit_nxt;
  logic [7:0]  tx_sh_r, tx_sh_nxt;
  logic        txd_nxt, tx_push, tx_pop, fifo_en_r;
  logic        fifo_en_nxt;

  always_comb begin
    tx_push     = hold_wr && (tx_cnt_r < (fifo_en_r ? CNT_FULL : CNT_ONE));
    tx_pop      = (tx_st_r == SER_IDLE) && (tx_cnt_r != '0);
    tx_wp_nxt   = tx_wp_r;
    tx_rp_nxt   = tx_rp_r;
    tx_cnt_nxt  = tx_cnt_r;
    tx_st_nxt   = tx_st_r;
    tx_tick_nxt = tx_tick_r;
    tx_bit_nxt  = tx_bit_r;
    tx_sh_nxt   = tx_sh_r;
    txd_nxt     = txd_o;
    if (tx_push) begin
      tx_wp_nxt = tx_wp_r + 1'b1;
    end
    if (tx_pop) begin
      tx_rp_nxt   = tx_rp_r + 1'b1;
      tx_sh_nxt   = tx_mem[tx_rp_r];
      tx_st_nxt   = SER_START;
      tx_tick_nxt = 4'h0;
      txd_nxt     = 1'b0;
    end
    tx_cnt_nxt = tx_cnt_r + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    if (baud_tick_i && tx_st_r != SER_IDLE) begin
      tx_tick_nxt = tx_tick_r + 4'h1;
      if (tx_tick_r == BIT_LAST_TICK) begin
        case (tx_st_r)
          SER_START: begin
            tx_st_nxt  = SER_DATA;
            tx_bit_nxt = 3'h0;
            txd_nxt    = tx_sh_r[0];
          end
          SER_DATA: begin
            tx_sh_nxt  = {1'b0, tx_sh_r[7:1]};
            tx_bit_nxt = tx_bit_r + 3'h1;
            txd_nxt    = (tx_bit_r == BIT_LAST) ? 1'b1 : tx_sh_r[1];
            if (tx_bit_r == BIT_LAST) begin
              tx_st_nxt = SER_STOP;
            end
          end
          SER_STOP: tx_st_nxt = SER_IDLE;
          default:  tx_st_nxt = SER_IDLE;
        endcase
      end
    end
    if (fcr_wr && host_req_i.wdata[FCR_TX_RST]) begin
      tx_wp_nxt  = '0;
      tx_rp_nxt  = '0;
      tx_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_wp_r   <= '0;
      tx_rp_r   <= '0;
      tx_cnt_r  <= '0;
      tx_st_r   <= SER_IDLE;
      tx_tick_r <= 4'h0;
      tx_bit_r  <= 3'h0;
      tx_sh_r   <= DATA_ZERO;
      txd_o     <= 1'b1;
    end else begin
      tx_wp_r   <= tx_wp_nxt;
      tx_rp_r   <= tx_rp_nxt;
      tx_cnt_r  <= tx_cnt_nxt;
      tx_st_r   <= tx_st_nxt;
      tx_tick_r <= tx_tick_nxt;
      tx_bit_r  <= tx_bit_nxt;
      tx_sh_r   <= tx_sh_nxt;
      txd_o     <= txd_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (tx_push) begin
      tx_mem[tx_wp_r] <= host_req_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive shifter and fifo
  logic [7:0]  rx_mem [DEPTH];
  logic [AW-1:0] rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
  logic [AW:0] rx_cnt_r, rx_cnt_nxt;
  uhri_ser_t   rx_st_r, rx_st_nxt;
  logic [3:0]  rx_tick_r, rx_tick_nxt;
  logic [2:0]  rx_bit_r, rx_bit_nxt;
  logic [7:0]  rx_sh_r, rx_sh_nxt;
  logic        rxd_prev_r, rx_push, rx_pop;
  logic        oe_r, oe_nxt, fe_r, fe_nxt, bi_r, bi_nxt;

  always_comb begin
    rx_push     = 1'b0;
    rx_pop      = hold_rd && (rx_cnt_r != '0);
    rx_wp_nxt   = rx_wp_r;
    rx_rp_nxt   = rx_rp_r + AW'(rx_pop);
    rx_st_nxt   = rx_st_r;
    rx_tick_nxt = rx_tick_r;
    rx_bit_nxt  = rx_bit_r;
    rx_sh_nxt   = rx_sh_r;
    oe_nxt      = lsr_rd ? 1'b0 : oe_r;
    fe_nxt      = lsr_rd ? 1'b0 : fe_r;
    bi_nxt      = lsr_rd ? 1'b0 : bi_r;
    case (rx_st_r)
      SER_IDLE: begin
        if (rxd_prev_r && !rxd_i) begin
          rx_st_nxt   = SER_START;
          rx_tick_nxt = 4'h0;
        end
      end
      SER_START: begin
        if (baud_tick_i) begin
          rx_tick_nxt = rx_tick_r + 4'h1;
          if (rx_tick_r == START_MID_TICK) begin
            rx_st_nxt   = rxd_i ? SER_IDLE : SER_DATA;
            rx_tick_nxt = 4'h0;
            rx_bit_nxt  = 3'h0;
          end
        end
      end
      SER_DATA: begin
        if (baud_tick_i) begin
          rx_tick_nxt = rx_tick_r + 4'h1;
          if (rx_tick_r == BIT_LAST_TICK) begin
            rx_sh_nxt  = {rxd_i, rx_sh_r[7:1]};
            rx_bit_nxt = rx_bit_r + 3'h1;
            if (rx_bit_r == BIT_LAST) begin
              rx_st_nxt = SER_STOP;
            end
          end
        end
      end
      SER_STOP: begin
        if (baud_tick_i && rx_tick_r == BIT_LAST_TICK) begin
          rx_st_nxt = SER_IDLE;
          if (rx_cnt_r < (fifo_en_r ? CNT_FULL : CNT_ONE) || rx_pop) begin
            rx_push   = 1'b1;
            rx_wp_nxt = rx_wp_r + 1'b1;
          end else begin
            oe_nxt = 1'b1;
          end
          if (!rxd_i) begin
            fe_nxt = 1'b1;
            bi_nxt = (rx_sh_r == DATA_ZERO) ? 1'b1 : bi_nxt;
          end
        end else if (baud_tick_i) begin
          rx_tick_nxt = rx_tick_r + 4'h1;
        end
      end
      default: rx_st_nxt = SER_IDLE;
    endcase
    rx_cnt_nxt = rx_cnt_r + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    if (fcr_wr && host_req_i.wdata[FCR_RX_RST]) begin
      rx_wp_nxt  = '0;
      rx_rp_nxt  = '0;
      rx_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_wp_r    <= '0;
      rx_rp_r    <= '0;
      rx_cnt_r   <= '0;
      rx_st_r    <= SER_IDLE;
      rx_tick_r  <= 4'h0;
      rx_bit_r   <= 3'h0;
      rx_sh_r    <= DATA_ZERO;
      rxd_prev_r <= 1'b1;
      oe_r       <= 1'b0;
      fe_r       <= 1'b0;
      bi_r       <= 1'b0;
    end else begin
      rx_wp_r    <= rx_wp_nxt;
      rx_rp_r    <= rx_rp_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      rx_st_r    <= rx_st_nxt;
      rx_tick_r  <= rx_tick_nxt;
      rx_bit_r   <= rx_bit_nxt;
      rx_sh_r    <= rx_sh_nxt;
      rxd_prev_r <= rxd_i;
      oe_r       <= oe_nxt;
      fe_r       <= fe_nxt;
      bi_r       <= bi_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rx_push) begin
      rx_mem[rx_wp_r] <= rx_sh_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // enable, status, readback and interrupt
  logic [7:0] ier_r, ier_nxt, line_status_reg, modem_status_reg, rdata_nxt;
  logic [3:0] mdelta_r, mdelta_nxt;
  logic [2:0] evt_r, evt_nxt;
  logic       irq_nxt, thre, rx_ready;

  always_comb begin
    thre     = (tx_cnt_r == '0);
    rx_ready = fifo_en_r ? (rx_cnt_r >= CNT_TRIG) : (rx_cnt_r != '0);
    line_status_reg      = {oe_r | fe_r | bi_r, thre && tx_st_r == SER_IDLE, thre, bi_r, fe_r,
                1'b0, oe_r, rx_cnt_r != '0};
    modem_status_reg      = {pin_s2_r[PIN_CD], pin_s2_r[PIN_RI], pin_s2_r[PIN_DSR], pin_s2_r[PIN_CTS],
                mdelta_r};
    ier_nxt  = ier_r;
    if (ier_wr) begin
      ier_nxt[3:0] = host_req_i.wdata[3:0];
      if (enh_feature_en_i) begin
        ier_nxt[7:4] = host_req_i.wdata[7:4];
      end
    end
    fifo_en_nxt = fcr_wr ? host_req_i.wdata[FCR_FIFO_EN] : fifo_en_r;
    mdelta_nxt  = (msr_rd ? 4'h0 : mdelta_r) |
                  {pin_chg[PIN_CD], pin_s2_r[PIN_RI] == 1'b0 && pin_prev_r[PIN_RI],
                   pin_chg[PIN_DSR], pin_chg[PIN_CTS]};
    evt_nxt     = (msr_rd ? 3'h0 : evt_r) |
                  {pin_rise[PIN_CTS], pin_rise[PIN_RTS], xoff_rx_i};
    case (host_req_i.addr)
      ADDR_HOLD: rdata_nxt = rx_mem[rx_rp_r];
      ADDR_IER:  rdata_nxt = ier_r;
      ADDR_LSR:  rdata_nxt = line_status_reg;
      ADDR_MSR:  rdata_nxt = modem_status_reg;
      default:   rdata_nxt = DATA_ZERO;
    endcase
    if (!rd_any) begin
      rdata_nxt = rdata_o;
    end
    irq_nxt = (ier_r[IER_CTS]   && evt_r[2])
            | (ier_r[IER_RTS]   && evt_r[1])
            | (ier_r[IER_XOFF]  && evt_r[0])
            | (ier_r[IER_MODEM] && mdelta_r != 4'h0)
            | (ier_r[IER_LINE]  && line_status_reg[4:1] != 4'h0)
            | (ier_r[IER_TXE]   && thre)
            | (ier_r[IER_RXR]   && rx_ready);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ier_r     <= IER_RST;
      fifo_en_r <= 1'b0;
      mdelta_r  <= 4'h0;
      evt_r     <= 3'h0;
      rdata_o   <= DATA_ZERO;
      irq_o     <= 1'b0;
      sleep_o   <= 1'b0;
    end else begin
      ier_r     <= ier_nxt;
      fifo_en_r <= fifo_en_nxt;
      mdelta_r  <= mdelta_nxt;
      evt_r     <= evt_nxt;
      rdata_o   <= rdata_nxt;
      irq_o     <= irq_nxt;
      sleep_o   <= ier_nxt[IER_SLEEP];
    end
  end
endmodule : uhri_chan

// >>> uhri_chan_sva.sv
// checker: port-level assertions of the uart holding block
`timescale 1ns/1ps
module uhri_chan_sva
  import uhri_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire uhri_req_t  host_req_i,
  input wire logic [7:0] rdata_o,
  input wire logic       baud_tick_i,
  input wire logic       rxd_i,
  input wire logic       txd_o,
  input wire logic       cts_i,
  input wire logic       dsr_i,
  input wire logic       ri_i,
  input wire logic       cd_i,
  input wire logic       rts_i,
  input wire logic       enh_feature_en_i,
  input wire logic       xoff_rx_i,
  input wire logic       irq_o,
  input wire logic       sleep_o
);
  logic [7:0] ier_r;
  logic [7:0] ier_nxt;
  logic       rd_lsr;
  assign rd_lsr = host_req_i.cs && host_req_i.rd && host_req_i.addr == ADDR_LSR;
  // mirror of the enable mask
  always_comb begin
    ier_nxt = ier_r;
    if (host_req_i.cs && host_req_i.wr && host_req_i.addr == ADDR_IER) begin
      ier_nxt[3:0] = host_req_i.wdata[3:0];
      if (enh_feature_en_i) begin
        ier_nxt[7:4] = host_req_i.wdata[7:4];
      end
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ier_r <= IER_RST;
    end else begin
      ier_r <= ier_nxt;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_hold: assert property ($changed(rdata_o) |-> $past(host_req_i.cs && host_req_i.rd))
    else $error("read data moved without a read");
  a_lsr_spare: assert property (rd_lsr |=> rdata_o[2] == 1'b0)
    else $error("line status bit 2 set");
  a_lsr_summary: assert property (rd_lsr |=> rdata_o[7] == (rdata_o[1] | rdata_o[3] | rdata_o[4]))
    else $error("line status summary bit wrong");
  a_sleep_follow: assert property ($stable(ier_r[IER_SLEEP]) [*3] |-> sleep_o == ier_r[IER_SLEEP])
    else $error("sleep output differs from enable bit");
  a_sleep_set: assert property (host_req_i.cs && host_req_i.wr && host_req_i.addr == ADDR_IER
    && enh_feature_en_i && host_req_i.wdata[IER_SLEEP] |-> ##[1:2] sleep_o)
    else $error("sleep not entered");
  a_irq_masked: assert property (ier_r == IER_RST && $past(ier_r) == IER_RST
    && $past(ier_r, 2) == IER_RST |-> !irq_o)
    else $error("interrupt with all sources masked");
  a_xoff_irq: assert property (xoff_rx_i && ier_r[IER_XOFF] && $past(ier_r[IER_XOFF])
    |-> ##[1:3] irq_o)
    else $error("stop character gave no interrupt");
  a_cts_irq: assert property ($rose(cts_i) && ier_r[IER_CTS] && $past(ier_r[IER_CTS])
    |-> ##[2:6] irq_o)
    else $error("clear-to-send rise gave no interrupt");
  a_rts_irq: assert property ($rose(rts_i) && ier_r[IER_RTS] && $past(ier_r[IER_RTS])
    |-> ##[2:6] irq_o)
    else $error("request-to-send rise gave no interrupt");
endmodule : uhri_chan_sva
bind uhri_chan uhri_chan_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i), .host_req_i(host_req_i),
  .rdata_o(rdata_o), .baud_tick_i(baud_tick_i), .rxd_i(rxd_i), .txd_o(txd_o), .cts_i(cts_i),
  .dsr_i(dsr_i), .ri_i(ri_i), .cd_i(cd_i), .rts_i(rts_i), .enh_feature_en_i(enh_feature_en_i),
  .xoff_rx_i(xoff_rx_i), .irq_o(irq_o), .sleep_o(sleep_o));

// >>> uhri_peer.sv
// serial peer: sends frames on the receive line, idle high
`timescale 1ns/1ps
module uhri_peer (
  input  wire logic clk_i,
  input  wire logic tick_i,
  output logic      rxd_o
);
  initial rxd_o = 1'b1;
  task automatic hold(input int n);
    int k;
    k = 0;
    while (k < n) begin
      @(posedge clk_i);
      if (tick_i) k++;
    end
    #1;
  endtask : hold
  // lsb first, stop level selectable
  task automatic send_byte(input logic [7:0] b, input logic stop);
    rxd_o = 1'b0;
    hold(16);
    for (int i = 0; i < 8; i++) begin
      rxd_o = b[i];
      hold(16);
    end
    rxd_o = stop;
    hold(16);
    rxd_o = 1'b1;
    hold(32);
  endtask : send_byte
  // low pulse far shorter than half a bit
  task automatic false_start();
    rxd_o = 1'b0;
    hold(4);
    rxd_o = 1'b1;
    hold(32);
  endtask : false_start
endmodule : uhri_peer

// >>> tb_top.sv
// testbench: register and serial scenarios of the uart holding block
`timescale 1ns/1ps
module tb_top
  import uhri_pkg::*;
;
  logic       clk = 1'b0;
  logic       rstn, tick, rxd, txd, cts, dsr, rts, enh, xoff, irq, sleep;
  logic [1:0] tcnt = 2'h0;
  logic [7:0] rdata;
  uhri_req_t  req;
  int         mismatches = 0;
  int         num_checks = 0;
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    #1;
    tcnt = tcnt + 2'h1;
    tick = (tcnt == 2'h0);
  end
  initial tick = 1'b0;
  uhri_chan DUT (.clk_i(clk), .rstn_i(rstn), .host_req_i(req), .rdata_o(rdata),
    .baud_tick_i(tick), .rxd_i(rxd), .txd_o(txd), .cts_i(cts), .dsr_i(dsr), .ri_i(1'b0),
    .cd_i(1'b0), .rts_i(rts), .enh_feature_en_i(enh), .xoff_rx_i(xoff), .irq_o(irq),
    .sleep_o(sleep));
  uhri_peer peer (.clk_i(clk), .tick_i(tick), .rxd_o(rxd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{1'b1, 1'b0, 1'b1, a, d};
    @(posedge clk);
    #1 req = '0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 req = '{1'b1, 1'b1, 1'b0, a, DATA_ZERO};
    @(posedge clk);
    #1 req = '0;
    d = rdata;
  endtask : rd
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rdc
  task automatic pin(input int k, input logic v);
    case (k)
      0: cts = v;
      1: rts = v;
      2: xoff = v;
      default: dsr = v;
    endcase
  endtask : pin
  // sample one transmitted frame at mid-bit, 64 clocks a bit
  task automatic tx_frame(input logic [7:0] e);
    logic [7:0] b;
    int n;
    n = 0;
    while (txd === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    if (n >= 400) begin
      mismatches++;
      summarize();
    end
    cyc(32);
    for (int i = 0; i < 8; i++) begin
      cyc(64);
      b[i] = txd;
    end
    chk(b, e);
    cyc(64);
    chk({7'h00, txd}, 8'h01);
  endtask : tx_frame
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [7:0] tab [4];
    tab = '{8'h80, 8'h40, 8'h20, 8'h08};
    req = '0;
    {enh, cts, dsr, rts, xoff, rstn} = 6'h00;
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    rdc(ADDR_IER, IER_RST);
    rdc(ADDR_LSR, 8'h60);
    chk({7'h00, sleep}, 8'h00);
    wr(ADDR_IER, 8'hf5);
    rdc(ADDR_IER, 8'h05);
    enh = 1'b1;
    wr(ADDR_IER, 8'h10);
    rdc(ADDR_IER, 8'h10);
    cyc(2);
    chk({7'h00, sleep}, 8'h01);
    wr(ADDR_IER, 8'h02);
    cyc(3);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_IER, 8'h00);
    cyc(3);
    chk({7'h00, irq}, 8'h00);
    $display("test enable done");
    wr(ADDR_HOLD, 8'h55);
    tx_frame(8'h55);
    cyc(40);
    rdc(ADDR_LSR, 8'h60);
    $display("test transmit done");
    wr(ADDR_IER, 8'h01);
    peer.false_start();
    rdc(ADDR_LSR, 8'h60);
    peer.send_byte(8'ha5, 1'b1);
    chk({7'h00, irq}, 8'h01);
    rdc(ADDR_LSR, 8'h61);
    rdc(ADDR_HOLD, 8'ha5);
    cyc(3);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_IER, 8'h04);
    peer.send_byte(8'h00, 1'b0);
    chk({7'h00, irq}, 8'h01);
    rdc(ADDR_LSR, 8'hf9);
    rdc(ADDR_HOLD, 8'h00);
    cyc(3);
    chk({7'h00, irq}, 8'h00);
    rdc(ADDR_LSR, 8'h60);
    $display("test receive done");
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_IER, 8'h00);
      cyc(4);
      rd(ADDR_MSR, v);
      wr(ADDR_IER, tab[k]);
      cyc(1);
      pin(k, 1'b1);
      cyc(1);
      if (k == 2) pin(k, 1'b0);
      cyc(6);
      chk({7'h00, irq}, 8'h01);
      rd(ADDR_MSR, v);
      if (k == 0) chk(v, 8'h11);
      cyc(3);
      chk({7'h00, irq}, 8'h00);
    end
    wr(ADDR_IER, 8'h00);
    $display("test modem done");
    wr(ADDR_FCR, 8'h01);
    wr(ADDR_HOLD, 8'h11);
    wr(ADDR_HOLD, 8'h22);
    wr(ADDR_HOLD, 8'h33);
    rd(ADDR_LSR, v);
    chk({7'h00, v[5]}, 8'h00);
    tx_frame(8'h11);
    tx_frame(8'h22);
    tx_frame(8'h33);
    $display("test fifo done");
    summarize();
  end
endmodule : tb_top
